/* src/windowed_watchdog_timer.sv */
// Windowed watchdog timer with reset-control bits and interrupt
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Counter keeps running in Sleep and Idle when enabled.
// - Low-power time-out wakes core, which resumes after the power-save instruction.
// - Sleep and Idle bits stay set after wake-up until software clears them.
// - Hardware enable fuse set: watchdog runs until a config write clears the fuse; the software enable bit cannot stop it.
// - Fuse cleared: watchdog runs only while software enable bit 5 is set.
// - Any device reset clears the software enable bit.
// - Windowed mode: a clear before the window opens resets the device at once.
// - Time-out flag bit 4 sets on time-out and holds until software clears.
// - Clocked by the 32 kHz oscillator, enabled whenever the watchdog is.
// - Prescaler divides by 32 or 128 per prescale select fuse.
// - Four-bit postscaler divides further, 1:1 up to 1:32768.
// - Counters clear on reset, clock switch, power-save entry and exit, clear.
module windowed_watchdog_timer (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // Register port
    input wire watchdog_pkg::reg_req_t i_reg,
    output logic [watchdog_pkg::DATA_W-1:0] o_rdata,
    // Core events
    input wire watchdog_pkg::core_req_t i_core,
    // Results to the core and clock tree
    output logic o_watchdog_reset,
    output logic o_wake,
    output logic o_low_power,
    output logic o_osc_en,
    output logic o_irq
);
    import watchdog_pkg::*;

    power_state_t pwr_r, pwr_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic sw_en_r, sw_en_nxt;
    logic timeout_flag_r, timeout_flag_nxt;
    logic sleep_flag_r, sleep_flag_nxt;
    logic idle_flag_r, idle_flag_nxt;
    watchdog_config_word_t cfg_r, cfg_nxt;
    logic [IRQ_W-1:0] irq_status_r, irq_status_nxt;
    logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic dog_reset_r, wake_r, irq_r, osc_en_r, low_power_r;
    logic enabled, osc_tick, timeout, early_clear, dog_rst, dev_reset, wake_lp;
    logic cnt_clear, wr_rc, in_run;
    logic [4:0] period_shift;
    logic [CNT_W:0] period;
    logic [CNT_W-1:0] last_cnt, win_start;

    // Enable, oscillator tick and period decode
    always_comb begin
        enabled = cfg_r.hw_watchdog_enable_fuse | sw_en_r;
        in_run = (pwr_r == PWR_RUN);
        osc_tick = enabled && (div_r == DIV_W'(OSC_DIV - 1));
        period_shift = (cfg_r.prescale_select_fuse ? PRE_SHIFT_SLOW : PRE_SHIFT_FAST)
                       + {1'b0, cfg_r.postscale_select_field};
        period = (CNT_W+1)'(1) << period_shift;
        last_cnt = CNT_W'(period - (CNT_W+1)'(1));
        // Window opens at three quarters of the period
        win_start = CNT_W'(period - (period >> 2));
        timeout = osc_tick && (cnt_r == last_cnt);
        early_clear = i_core.watchdog_clear_instr && enabled && in_run
                      && !cfg_r.window_disable_fuse && (cnt_r < win_start);
        dog_rst = in_run && (timeout || early_clear);
        wake_lp = !in_run && timeout;
        dev_reset = i_core.device_reset || dog_rst;
        wr_rc = i_reg.wr && (i_reg.addr == ADDR_RESET_CTRL);
        // Clearing also on disable keeps a re-enable from inheriting a stale count
        cnt_clear = dev_reset || i_core.clock_switch_done || !enabled
                    || (in_run && i_core.power_save_instr)
                    || (!in_run && (timeout || i_core.wake_other))
                    || (in_run && i_core.watchdog_clear_instr);
    end

    // Oscillator divider, counter and power state
    always_comb begin
        div_nxt = div_r;
        cnt_nxt = cnt_r;
        pwr_nxt = pwr_r;
        if (!enabled || osc_tick) begin
            div_nxt = '0;
        end else begin
            div_nxt = div_r + DIV_W'(1);
        end
        // Counting goes on whatever the power state
        if (cnt_clear) begin
            cnt_nxt = '0;
        end else if (osc_tick) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
        unique case (pwr_r)
            PWR_RUN: begin
                if (i_core.power_save_instr && !dev_reset) begin
                    pwr_nxt = i_core.idle_select ? PWR_IDLE : PWR_SLEEP;
                end
            end
            PWR_SLEEP, PWR_IDLE: begin
                if (timeout || i_core.wake_other) begin
                    pwr_nxt = PWR_RUN;
                end
            end
            default: begin
                pwr_nxt = PWR_RUN;
            end
        endcase
        if (i_core.device_reset) begin
            pwr_nxt = PWR_RUN;
        end
    end

    // Register file, flags and interrupt; hardware set wins over software clear
    always_comb begin
        sw_en_nxt = sw_en_r;
        timeout_flag_nxt = timeout_flag_r;
        sleep_flag_nxt = sleep_flag_r;
        idle_flag_nxt = idle_flag_r;
        cfg_nxt = cfg_r;
        irq_status_nxt = irq_status_r;
        irq_mask_nxt = irq_mask_r;
        rdata_nxt = '0;
        if (wr_rc) begin
            sw_en_nxt = i_reg.wdata[RC_SW_EN_BIT];
            timeout_flag_nxt = i_reg.wdata[RC_TIMEOUT_BIT];
            sleep_flag_nxt = i_reg.wdata[RC_SLEEP_BIT];
            idle_flag_nxt = i_reg.wdata[RC_IDLE_BIT];
        end
        if (i_reg.wr && i_reg.addr == ADDR_CONFIG) begin
            cfg_nxt = i_reg.wdata[CFG_W-1:0];
        end
        if (i_reg.wr && i_reg.addr == ADDR_IRQ_MASK) begin
            irq_mask_nxt = i_reg.wdata[IRQ_W-1:0];
        end
        if (i_reg.wr && i_reg.addr == ADDR_IRQ_STATUS) begin
            irq_status_nxt = irq_status_r & ~i_reg.wdata[IRQ_W-1:0];
        end
        // Hardware sets after software writes
        if (timeout || early_clear) begin
            timeout_flag_nxt = 1'b1;
            irq_status_nxt[IRQ_TIMEOUT_BIT] = 1'b1;
        end
        if (early_clear) begin
            irq_status_nxt[IRQ_WINDOW_BIT] = 1'b1;
        end
        if (wake_lp) begin
            irq_status_nxt[IRQ_WAKE_BIT] = 1'b1;
        end
        // Power-save entry sets the matching bit; wake-up leaves it alone
        if (in_run && i_core.power_save_instr && !dev_reset) begin
            if (i_core.idle_select) begin
                idle_flag_nxt = 1'b1;
            end else begin
                sleep_flag_nxt = 1'b1;
            end
        end
        if (dev_reset) begin
            sw_en_nxt = 1'b0;
        end
        if (i_reg.rd) begin
            unique case (i_reg.addr)
                ADDR_RESET_CTRL: begin
                    rdata_nxt[RC_SW_EN_BIT] = sw_en_r;
                    rdata_nxt[RC_TIMEOUT_BIT] = timeout_flag_r;
                    rdata_nxt[RC_SLEEP_BIT] = sleep_flag_r;
                    rdata_nxt[RC_IDLE_BIT] = idle_flag_r;
                end
                ADDR_CONFIG: rdata_nxt[CFG_W-1:0] = cfg_r;
                ADDR_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = irq_status_r;
                ADDR_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = irq_mask_r;
            endcase
        end
    end

    // State registers; flags and configuration survive device reset, only power-up clears them
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pwr_r <= PWR_RUN;
            cnt_r <= '0;
            div_r <= '0;
            sw_en_r <= 1'b0;
            timeout_flag_r <= 1'b0;
            sleep_flag_r <= 1'b0;
            idle_flag_r <= 1'b0;
            cfg_r <= CONFIG_RESET;
            irq_status_r <= '0;
            irq_mask_r <= IRQ_MASK_RESET;
            rdata_r <= '0;
            dog_reset_r <= 1'b0;
            wake_r <= 1'b0;
            irq_r <= 1'b0;
            osc_en_r <= 1'b0;
            low_power_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            sw_en_r <= sw_en_nxt;
            timeout_flag_r <= timeout_flag_nxt;
            sleep_flag_r <= sleep_flag_nxt;
            idle_flag_r <= idle_flag_nxt;
            cfg_r <= cfg_nxt;
            irq_status_r <= irq_status_nxt;
            irq_mask_r <= irq_mask_nxt;
            rdata_r <= rdata_nxt;
            dog_reset_r <= dog_rst;
            wake_r <= wake_lp;
            irq_r <= |(irq_status_nxt & irq_mask_nxt);
            osc_en_r <= enabled;
            // Own flop so the pin carries no decode glitch
            low_power_r <= (pwr_nxt != PWR_RUN);
        end
    end

    assign o_rdata = rdata_r;
    assign o_watchdog_reset = dog_reset_r;
    assign o_wake = wake_r;
    assign o_low_power = low_power_r;
    assign o_osc_en = osc_en_r;
    assign o_irq = irq_r;

    // One-cycle reset request, then quiet
    sequence s_reset_pulse;
        o_watchdog_reset ##1 !o_watchdog_reset;
    endsequence
    sequence s_wake_pulse;
        o_wake && !o_watchdog_reset && !o_low_power;
    endsequence

    lp_count_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (!in_run && osc_tick && !timeout && !i_core.wake_other && !i_core.device_reset
         && !i_core.clock_switch_done) |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("counter stalled in low power");
    lp_wake_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (wake_lp && !i_core.device_reset) |=> s_wake_pulse)
        else $error("low-power time-out did not wake");
    lp_flags_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (sleep_flag_r && !wr_rc) |=> sleep_flag_r)
        else $error("sleep bit lost without software");
    hw_always_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        cfg_r.hw_watchdog_enable_fuse |=> o_osc_en)
        else $error("fuse set but watchdog stopped");
    sw_gate_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (!cfg_r.hw_watchdog_enable_fuse && !sw_en_r) |=> (!o_osc_en && cnt_r == '0))
        else $error("watchdog ran while disabled");
    reset_sw_en_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        dev_reset |=> !sw_en_r)
        else $error("device reset kept software enable");
    // A clear right behind the first may legally raise a second pulse, so it is left out
    early_clear_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        early_clear ##1 !i_core.watchdog_clear_instr |-> s_reset_pulse)
        else $error("early clear did not reset");
    flag_set_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        timeout |=> timeout_flag_r [*2] or (timeout_flag_r ##1 $past(wr_rc)))
        else $error("time-out flag not set or held");
    run_reset_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (in_run && timeout) ##1 !i_core.watchdog_clear_instr
        |-> (s_reset_pulse and (timeout_flag_r && !o_wake)))
        else $error("run time-out did not reset");
    // A time-out landing in the same cycle as the clear still wins
    clear_restart_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_core.watchdog_clear_instr && in_run && cfg_r.window_disable_fuse && !timeout)
        |=> (cnt_r == '0 && !o_watchdog_reset))
        else $error("clear did not restart count");
    lp_no_reset_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (!in_run && timeout) |=> !o_watchdog_reset)
        else $error("low-power time-out reset the device");
    lp_entry_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (in_run && i_core.power_save_instr && !dev_reset) |=> (o_low_power && (sleep_flag_r || idle_flag_r)))
        else $error("power-save entry not flagged");
    idle_hold_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (idle_flag_r && !wr_rc) |=> idle_flag_r)
        else $error("idle bit lost without software");
    osc_enable_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        enabled |=> o_osc_en)
        else $error("oscillator off while watchdog enabled");

    // Period ends: 32 or 128 ticks per base period, times 1 or 32768
    pre_fast_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (timeout && !cfg_r.prescale_select_fuse && cfg_r.postscale_select_field == 4'h0) |-> cnt_r == 22'h00001f)
        else $error("fast prescale period wrong");
    pre_slow_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (timeout && cfg_r.prescale_select_fuse && cfg_r.postscale_select_field == 4'h0) |-> cnt_r == 22'h00007f)
        else $error("slow prescale period wrong");
    post_fast_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (timeout && !cfg_r.prescale_select_fuse && cfg_r.postscale_select_field == 4'hf) |-> cnt_r == 22'h0fffff)
        else $error("longest fast postscale wrong");
    post_slow_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (timeout && cfg_r.prescale_select_fuse && cfg_r.postscale_select_field == 4'hf) |-> cnt_r == 22'h3fffff)
        else $error("longest slow postscale wrong");

    // Counter restarts on clock switch and power-save entry, not only on the clear instruction
    clear_sources_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (i_core.clock_switch_done || (in_run && i_core.power_save_instr)) |=> cnt_r == '0)
        else $error("counter not cleared by event");
    // Read data stand for one cycle only
    rdata_idle_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !i_reg.rd |=> o_rdata == '0)
        else $error("read data outside read cycle");
endmodule : windowed_watchdog_timer

`default_nettype wire

/* src/wdt_pkg.sv */
// Constants, layouts and types of the windowed watchdog timer
package watchdog_pkg;
    // Register indices on the plain register port
    localparam int ADDR_W = 2;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 2'h3;
    // Bit positions of reset_control_reg
    localparam int RC_IDLE_BIT = 2;
    localparam int RC_SLEEP_BIT = 3;
    localparam int RC_TIMEOUT_BIT = 4;
    localparam int RC_SW_EN_BIT = 5;
    // Bit positions of the interrupt status and mask registers
    localparam int IRQ_W = 3;
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_WINDOW_BIT = 1;
    localparam int IRQ_WAKE_BIT = 2;
    localparam int CFG_W = 8;
    // Prescaler widths: divide by 32 or by 128
    localparam logic [4:0] PRE_SHIFT_FAST = 5'h05;
    localparam logic [4:0] PRE_SHIFT_SLOW = 5'h07;
    // Tick counter spans 128 x 32768 oscillator ticks
    localparam int CNT_W = 22;
    // Timing: oscillator ticks derived from the system clock
    localparam int CLOCK_HZ = 25000000;
    localparam int OSC_HZ = 32000;
    localparam int OSC_DIV = CLOCK_HZ / OSC_HZ;
    localparam int DIV_W = $clog2(OSC_DIV);

    // Configuration word layout
    typedef struct packed {
        logic hw_watchdog_enable_fuse;
        logic window_disable_fuse;
        logic reserved;
        logic prescale_select_fuse;
        logic [3:0] postscale_select_field;
    } watchdog_config_word_t;
    localparam watchdog_config_word_t CONFIG_RESET = 8'hdf;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    // Instruction events from the processor core, one-cycle pulses
    typedef struct packed {
        logic watchdog_clear_instr;
        logic power_save_instr;
        logic idle_select;
        logic clock_switch_done;
        logic wake_other;
        logic device_reset;
    } core_req_t;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_IDLE = 2'b10
    } power_state_t;
endpackage : watchdog_pkg

/* tb/core_model.sv */
// Behavioural processor core that issues instruction events to the watchdog
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock
    input wire logic i_clock,
    // Results from the watchdog
    input wire logic i_watchdog_reset,
    input wire logic i_wake,
    // Instruction events
    output var watchdog_pkg::core_req_t o_core
);
    import watchdog_pkg::*;
    int wake_count = 0;
    int reset_count = 0;
    initial o_core = '0;
    // Count each wake pulse and each watchdog reset pulse
    always @(posedge i_clock) begin
        if (i_wake === 1'b1) wake_count <= wake_count + 1;
        if (i_watchdog_reset === 1'b1) reset_count <= reset_count + 1;
    end
    // One event per call; the caller picks when, so clears may be early on purpose
    task automatic issue(input core_req_t ev);
        @(posedge i_clock);
        o_core <= ev;
        @(posedge i_clock);
        o_core <= '0;
    endtask : issue
endmodule : core_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the windowed watchdog timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import watchdog_pkg::*;
    localparam core_req_t CLR = '{watchdog_clear_instr: 1'b1, default: 1'b0};
    localparam core_req_t SLP = '{power_save_instr: 1'b1, default: 1'b0};
    localparam core_req_t IDL = '{power_save_instr: 1'b1, idle_select: 1'b1, default: 1'b0};
    localparam core_req_t WKO = '{wake_other: 1'b1, default: 1'b0};
    localparam core_req_t DRS = '{device_reset: 1'b1, default: 1'b0};
    localparam core_req_t CSW = '{clock_switch_done: 1'b1, default: 1'b0};
    logic i_clock = 1'b0;
    logic i_arst_n = 1'b0;
    reg_req_t i_reg = '0;
    core_req_t core_ev;
    logic [DATA_W-1:0] o_rdata;
    logic o_watchdog_reset, o_wake, o_low_power, o_osc_en, o_irq;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    // 25 MHz clock; a cycle ceiling cuts a hang short
    always #20 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            finish_test();
        end
    end

    windowed_watchdog_timer dut_u (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_reg(i_reg), .o_rdata(o_rdata),
        .i_core(core_ev), .o_watchdog_reset(o_watchdog_reset), .o_wake(o_wake), .o_low_power(o_low_power),
        .o_osc_en(o_osc_en), .o_irq(o_irq));
    core_model core_u (.i_clock(i_clock), .i_watchdog_reset(o_watchdog_reset), .i_wake(o_wake),
        .o_core(core_ev));

    // Shared comparison and bus cycles
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_reg <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
        i_reg <= '0;
    endtask : reg_wr
    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_reg <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        i_reg <= '0;
        #1 check(o_rdata, exp);
    endtask : reg_rd
    // Bounded wait for a wake or a watchdog reset pulse, counting cycles
    task automatic wait_evt(input logic is_wake, input int limit, output int cnt);
        cnt = 0;
        do begin
            @(posedge i_clock);
            #1 cnt++;
        end while (((is_wake ? o_wake : o_watchdog_reset) !== 1'b1) && cnt < limit);
    endtask : wait_evt

    task automatic test_reset_values();
        reg_rd(ADDR_RESET_CTRL, 16'h0000);
        reg_rd(ADDR_CONFIG, 16'h00df);
        reg_rd(ADDR_IRQ_MASK, 16'h0000);
        reg_rd(ADDR_IRQ_STATUS, 16'h0000);
        check(o_osc_en, 1'b1);
    endtask : test_reset_values

    // Windowed, hardware enabled, software bit low: an early clear resets at once
    task automatic test_early_clear();
        reg_wr(ADDR_CONFIG, 16'h0080);
        reg_wr(ADDR_IRQ_MASK, 16'h0003);
        core_u.issue(CLR);
        #1 check(o_watchdog_reset, 1'b1);
        reg_rd(ADDR_RESET_CTRL, 16'h0010);
        reg_rd(ADDR_IRQ_STATUS, 16'h0003);
        check(o_irq, 1'b1);
        reg_wr(ADDR_IRQ_MASK, 16'h0000);
        reg_rd(ADDR_IRQ_MASK, 16'h0000);
        check(o_irq, 1'b0);
        reg_wr(ADDR_IRQ_MASK, 16'h0003);
        reg_wr(ADDR_IRQ_STATUS, 16'h0003);
        reg_rd(ADDR_IRQ_STATUS, 16'h0000);
        check(o_irq, 1'b0);
        reg_rd(ADDR_RESET_CTRL, 16'h0010);
        reg_wr(ADDR_RESET_CTRL, 16'h0000);
        reg_rd(ADDR_RESET_CTRL, 16'h0000);
        // 19000 cycles puts the count at 24 or 25 of 32 ticks: inside the last quarter
        wait_evt(1'b0, 19000, n);
        check(16'(n), 16'd19000);
        core_u.issue(CLR);
        #1 check(o_watchdog_reset, 1'b0);
        reg_rd(ADDR_RESET_CTRL, 16'h0000);
    endtask : test_early_clear

    // Idle left by another source, then Sleep left by a watchdog time-out
    task automatic test_sleep_wake();
        core_u.issue(IDL);
        #1 check(o_low_power, 1'b1);
        core_u.issue(WKO);
        #1 check(o_low_power, 1'b0);
        reg_rd(ADDR_RESET_CTRL, 16'h0004);
        reg_wr(ADDR_RESET_CTRL, 16'h0000);
        core_u.issue(SLP);
        #1 check(o_low_power, 1'b1);
        core_u.issue(CLR);
        #1 check(o_watchdog_reset, 1'b0);
        reg_rd(ADDR_RESET_CTRL, 16'h0008);
        wait_evt(1'b1, 26000, n);
        check(16'(n >= 24000 && n <= 25900), 16'h0001);
        check(o_low_power, 1'b0);
        reg_rd(ADDR_RESET_CTRL, 16'h0018);
        reg_rd(ADDR_IRQ_STATUS, 16'h0005);
        check(16'(core_u.wake_count), 16'h0001);
    endtask : test_sleep_wake

    // Software enable with the fuse low; a mid-period clear restarts the count
    task automatic test_sw_enable();
        reg_wr(ADDR_RESET_CTRL, 16'h0000);
        reg_wr(ADDR_IRQ_STATUS, 16'h0007);
        reg_wr(ADDR_CONFIG, 16'h0040);
        reg_rd(ADDR_CONFIG, 16'h0040);
        check(o_osc_en, 1'b0);
        reg_wr(ADDR_RESET_CTRL, 16'h0020);
        core_u.issue(DRS);
        reg_rd(ADDR_RESET_CTRL, 16'h0000);
        reg_wr(ADDR_RESET_CTRL, 16'h0020);
        core_u.issue(CSW);
        reg_rd(ADDR_RESET_CTRL, 16'h0020);
        check(o_osc_en, 1'b1);
        wait_evt(1'b0, 12000, n);
        check(16'(n), 16'd12000);
        core_u.issue(CLR);
        #1 check(o_watchdog_reset, 1'b0);
        wait_evt(1'b0, 26000, n);
        check(16'(n >= 24000 && n <= 25900), 16'h0001);
        reg_rd(ADDR_RESET_CTRL, 16'h0010);
        reg_rd(ADDR_IRQ_STATUS, 16'h0001);
        // One pulse from the early clear, one from the run time-out, none from the legal clears
        check(16'(core_u.reset_count), 16'h0002);
    endtask : test_sw_enable

    task automatic finish_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // Reset for 8 cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge i_clock);
        i_arst_n <= 1'b1;
        test_reset_values();
        test_early_clear();
        test_sleep_wake();
        test_sw_enable();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
